// *** dio_port_regs.sv ***
// Digital I/O port register block: two output control words, two input
// status words and four 8-bit bidirectional ports with direction control.
// Assumes a synchronous single-cycle data-space bus on clk; pins and
// status lines arrive from outside the clock domain.

`timescale 1ns/1ps
`default_nettype none

module dio_port_regs (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rstn,
    // Peripheral data-space bus
    input  wire dio_pkg::dio_bus_req_type bus_req,
    output var  logic [15:0]            bus_rdata,
    output var  logic                   bus_rvalid,
    // Output control and input status lines
    output var  logic [15:0]            out_line_bits_a,
    output var  logic [15:0]            out_line_bits_b,
    input  wire logic [15:0]            in_level_bits_a,
    input  wire logic [15:0]            in_level_bits_b,
    // Bidirectional ports, index 0..3 for A..D
    input  wire logic [3:0][7:0]        pin_in,
    output var  logic [3:0][7:0]        pin_out,
    output var  logic [3:0][7:0]        pin_oe
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic in_window(input logic [15:0] a);
        return (a >= dio_pkg::WINDOW_BASE) && (a <= dio_pkg::WINDOW_LAST);
    endfunction

    function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
        return in_window(a) && (a == ofs);
    endfunction

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Stage one is read only by stage two; metastability stays contained.
    logic [15:0]      sync1_a_q;
    logic [15:0]      sync2_a_q;
    logic [15:0]      sync1_b_q;
    logic [15:0]      sync2_b_q;
    logic [3:0][7:0]  pin_sync1_q;
    logic [3:0][7:0]  pin_sync2_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1_a_q   <= dio_pkg::REG_RESET;
            sync2_a_q   <= dio_pkg::REG_RESET;
            sync1_b_q   <= dio_pkg::REG_RESET;
            sync2_b_q   <= dio_pkg::REG_RESET;
            pin_sync1_q <= '0;
            pin_sync2_q <= '0;
        end else begin
            sync1_a_q   <= in_level_bits_a;
            sync2_a_q   <= sync1_a_q;
            sync1_b_q   <= in_level_bits_b;
            sync2_b_q   <= sync1_b_q;
            pin_sync1_q <= pin_in;
            pin_sync2_q <= pin_sync1_q;
        end
    end

    // ------------------------------------------------------------
    // Output control registers
    // ------------------------------------------------------------
    // All 16 bits store, even where a device leaves a line unconnected.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            out_line_bits_a <= dio_pkg::REG_RESET;
            out_line_bits_b <= dio_pkg::REG_RESET;
        end else if (bus_req.wr) begin
            if (hit(bus_req.addr, dio_pkg::OFS_OUT_CTRL_A)) begin
                out_line_bits_a <= bus_req.wdata;
            end
            if (hit(bus_req.addr, dio_pkg::OFS_OUT_CTRL_B)) begin
                out_line_bits_b <= bus_req.wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Bidirectional port registers
    // ------------------------------------------------------------
    localparam logic [15:0] PORT_OFS [4] = '{dio_pkg::OFS_PORT_A, dio_pkg::OFS_PORT_B,
                                              dio_pkg::OFS_PORT_C, dio_pkg::OFS_PORT_D};

    dio_pkg::dio_port_reg_type port_q [4];

    genvar gp;
    generate
        for (gp = 0; gp < dio_pkg::NUM_PORTS; gp++) begin : g_port
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    port_q[gp].dir  <= dio_pkg::BYTE_RESET;
                    port_q[gp].data <= dio_pkg::BYTE_RESET;
                    pin_out[gp]     <= dio_pkg::BYTE_RESET;
                    pin_oe[gp]      <= dio_pkg::BYTE_RESET;
                end else if (bus_req.wr && hit(bus_req.addr, PORT_OFS[gp])) begin
                    port_q[gp].dir  <= bus_req.wdata[15:dio_pkg::DIR_LSB];
                    port_q[gp].data <= bus_req.wdata[7:0];
                    // Pins follow the register directly, no extra stage.
                    pin_out[gp]     <= bus_req.wdata[7:0];
                    pin_oe[gp]      <= bus_req.wdata[15:dio_pkg::DIR_LSB];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    function automatic logic [15:0] port_view(input dio_pkg::dio_port_reg_type r,
                                              input logic [7:0] sensed);
        // Output pins return the stored value, input pins the sensed level.
        return {r.dir, (r.dir & r.data) | (~r.dir & sensed)};
    endfunction

    logic [15:0] rdata_d;

    always_comb begin
        rdata_d = dio_pkg::UNMAPPED_READ;
        if (hit(bus_req.addr, dio_pkg::OFS_OUT_CTRL_A)) begin
            rdata_d = out_line_bits_a;
        end else if (hit(bus_req.addr, dio_pkg::OFS_OUT_CTRL_B)) begin
            rdata_d = out_line_bits_b;
        end else if (hit(bus_req.addr, dio_pkg::OFS_IN_STATUS_A)) begin
            rdata_d = sync2_a_q;
        end else if (hit(bus_req.addr, dio_pkg::OFS_IN_STATUS_B)) begin
            rdata_d = sync2_b_q;
        end else if (hit(bus_req.addr, dio_pkg::OFS_PORT_A)) begin
            rdata_d = port_view(port_q[0], pin_sync2_q[0]);
        end else if (hit(bus_req.addr, dio_pkg::OFS_PORT_B)) begin
            rdata_d = port_view(port_q[1], pin_sync2_q[1]);
        end else if (hit(bus_req.addr, dio_pkg::OFS_PORT_C)) begin
            rdata_d = port_view(port_q[2], pin_sync2_q[2]);
        end else if (hit(bus_req.addr, dio_pkg::OFS_PORT_D)) begin
            rdata_d = port_view(port_q[3], pin_sync2_q[3]);
        end
    end

    // Registered read answer: data one cycle after the strobe.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bus_rdata  <= dio_pkg::UNMAPPED_READ;
            bus_rvalid <= 1'b0;
        end else begin
            bus_rvalid <= bus_req.rd;
            if (bus_req.rd) begin
                bus_rdata <= rdata_d;
            end
        end
    end

endmodule

`default_nettype wire

// *** dio_pkg.sv ***
// Constants and carrier types for the digital I/O port register block.
// Assumes a 16-bit data-space peripheral bus with byte addresses; registers sit at even addresses.

package dio_pkg;

    // ------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------
    localparam logic [15:0] WINDOW_BASE       = 16'h7090;
    localparam logic [15:0] WINDOW_LAST       = 16'h709F;
    localparam logic [15:0] OFS_OUT_CTRL_A    = 16'h7090;
    localparam logic [15:0] OFS_OUT_CTRL_B    = 16'h7092;
    localparam logic [15:0] OFS_IN_STATUS_A   = 16'h7094;
    localparam logic [15:0] OFS_IN_STATUS_B   = 16'h7096;
    localparam logic [15:0] OFS_PORT_A        = 16'h7098;
    localparam logic [15:0] OFS_PORT_B        = 16'h709A;
    localparam logic [15:0] OFS_PORT_C        = 16'h709C;
    localparam logic [15:0] OFS_PORT_D        = 16'h709E;

    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int          NUM_PORTS         = 4;
    localparam int          PORT_PINS         = 8;
    localparam int          DIR_LSB           = 8;
    localparam logic [15:0] REG_RESET         = 16'h0000;
    localparam logic [7:0]  BYTE_RESET        = 8'h00;
    localparam logic [15:0] UNMAPPED_READ     = 16'h0000;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } dio_bus_req_type;

    typedef struct packed {
        logic [7:0] dir;
        logic [7:0] data;
    } dio_port_reg_type;

endpackage

// *** dio_port_regs_asserts.sv ***
// Checker for the digital I/O port block, bound to its top ports.
// Assumes one clock domain with an async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module dio_port_regs_asserts (
    // Clock, reset and bus
    input wire logic                     clk,
    input wire logic                     rstn,
    input wire dio_pkg::dio_bus_req_type bus_req,
    input wire logic [15:0]              bus_rdata,
    input wire logic                     bus_rvalid,
    // Lines and pins
    input wire logic [15:0]              out_line_bits_a,
    input wire logic [15:0]              out_line_bits_b,
    input wire logic [15:0]              in_level_bits_a,
    input wire logic [15:0]              in_level_bits_b,
    input wire logic [3:0][7:0]          pin_in,
    input wire logic [3:0][7:0]          pin_out,
    input wire logic [3:0][7:0]          pin_oe
);
    logic [15:0] ad;
    logic        rd;
    logic        wr;
    assign ad = bus_req.addr;
    assign rd = bus_req.rd;
    assign wr = bus_req.wr;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_oca; wr && ad == 16'h7090 |=> out_line_bits_a == $past(bus_req.wdata); endproperty
    a_oca: assert property (p_oca) else $error("line word a not written");
    property p_ocb; wr && ad == 16'h7092 |=> out_line_bits_b == $past(bus_req.wdata); endproperty
    a_ocb: assert property (p_ocb) else $error("line word b not written");
    property p_pa; wr && ad == 16'h7098 |=> {pin_oe[0], pin_out[0]} == $past(bus_req.wdata); endproperty
    a_pa: assert property (p_pa) else $error("port a drive wrong");
    property p_pd; wr && ad == 16'h709E |=> {pin_oe[3], pin_out[3]} == $past(bus_req.wdata); endproperty
    a_pd: assert property (p_pd) else $error("port d drive wrong");
    property p_hold; !(wr && ad == 16'h7090) |=> $stable(out_line_bits_a); endproperty
    a_hold: assert property (p_hold) else $error("line word a changed");
    property p_rba; rd && ad == 16'h7090 |=> bus_rdata == $past(out_line_bits_a); endproperty
    a_rba: assert property (p_rba) else $error("line word a readback");
    property p_unm; rd && (ad < 16'h7090 || ad > 16'h709F || ad[0]) |=> bus_rdata == 16'h0000; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
    property p_sta; ($stable(in_level_bits_a) && $past(rstn, 3))[*3] ##0 (rd && ad == 16'h7094)
        |=> bus_rdata == $past(in_level_bits_a); endproperty
    a_sta: assert property (p_sta) else $error("status a read wrong");
    property p_dir; rd && ad == 16'h7098 |=> bus_rdata[15:8] == $past(pin_oe[0]); endproperty
    a_dir: assert property (p_dir) else $error("port a direction read");
    // Read answer strobe stands exactly one cycle after each read strobe
    property p_rv; 1'b1 |=> bus_rvalid == $past(rd); endproperty
    a_rv: assert property (p_rv) else $error("read valid strobe wrong");
endmodule
`default_nettype wire

// *** dio_pin_model.sv ***
// Far-side pin model: a pin shows the block's drive where enabled.
// Assumes the bench sets the outside level of every released pin.
`timescale 1ns/1ps
`default_nettype none
module dio_pin_model (
    // Block side and outside sources
    input  wire logic [3:0][7:0] pin_out,
    input  wire logic [3:0][7:0] pin_oe,
    input  wire logic [3:0][7:0] ext_level,
    output var  logic [3:0][7:0] pin_in
);
    always_comb pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the digital I/O port register block.
// Assumes the pin model on the ports; inputs change at falling edges.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct packed {logic [15:0] a, w, e;} dio_row_type;
    logic                     clk = 1'b0;
    logic                     rstn = 1'b0;
    logic                     rv;
    dio_pkg::dio_bus_req_type req = '0;
    logic [15:0]              rdata, oca, ocb;
    logic [15:0]              ina = 16'h0000, inb = 16'h0000;
    logic [3:0][7:0]          pin_in, pin_out, pin_oe;
    logic [3:0][7:0]          ext = {4{8'h5A}};
    int                       failures = 0, n_tests = 0, cyc = 0;
    dio_row_type              rows [7] = '{'{16'h7090, 16'hA5C3, 16'hA5C3},
        '{16'h7092, 16'h8001, 16'h8001}, '{16'h7098, 16'hF00F, 16'hF00A},
        '{16'h709A, 16'hFF55, 16'hFF55}, '{16'h709C, 16'h0000, 16'h005A},
        '{16'h709E, 16'h01FF, 16'h015B}, '{16'h7094, 16'hFFFF, 16'h0000}};
    dio_port_regs u_dio_port_regs (.clk(clk), .rstn(rstn), .bus_req(req), .bus_rdata(rdata),
        .bus_rvalid(rv), .out_line_bits_a(oca), .out_line_bits_b(ocb), .in_level_bits_a(ina),
        .in_level_bits_b(inb), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
    dio_pin_model u_dio_pin_model (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext),
        .pin_in(pin_in));
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            failures++;
            finish_test();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Request held for one edge, read data settled by the next falling edge
    task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d);
        @(negedge clk);
        req = '{rd: !w, wr: w, addr: a, wdata: d};
        @(negedge clk);
        req.rd = 1'b0;
        req.wr = 1'b0;
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        foreach (rows[i]) begin
            xfer(1'b1, rows[i].a, rows[i].w);
            repeat (3) @(negedge clk);
            xfer(1'b0, rows[i].a, 16'h0000);
            chk(rdata, rows[i].e, "row read");
        end
        $display("register rows done");
        ina = 16'h8001;
        inb = 16'h7FFE;
        repeat (3) @(negedge clk);
        ina = 16'h0001;
        xfer(1'b0, 16'h7094, 16'h0000);
        chk(rdata, 16'h8001, "status a lag");
        repeat (3) @(negedge clk);
        xfer(1'b0, 16'h7094, 16'h0000);
        chk(rdata, 16'h0001, "status a");
        xfer(1'b0, 16'h7096, 16'h0000);
        chk(rdata, 16'h7FFE, "status b");
        $display("status done");
        xfer(1'b1, 16'h7091, 16'hFFFF);
        xfer(1'b0, 16'h7091, 16'h0000);
        chk(rdata, 16'h0000, "odd address");
        xfer(1'b0, 16'h70A0, 16'h0000);
        chk(rdata, 16'h0000, "outside window");
        xfer(1'b0, 16'h7090, 16'h0000);
        chk(rdata, 16'hA5C3, "line word a kept");
        chk(16'(rv), 16'h0001, "read valid");
        $display("unmapped done");
        ina = 16'h0000;
        inb = 16'h0000;
        ext = '0;
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        chk(oca | ocb, 16'h0000, "lines in reset");
        rstn = 1'b1;
        for (int k = 0; k < 8; k++) begin
            xfer(1'b0, 16'(16'h7090 + 2 * k), 16'h0000);
            chk(rdata, 16'h0000, "reset value");
        end
        $display("reset done");
        finish_test();
    end
endmodule
bind dio_port_regs dio_port_regs_asserts u_dio_port_regs_asserts (.clk(clk), .rstn(rstn),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
    .out_line_bits_a(out_line_bits_a), .out_line_bits_b(out_line_bits_b),
    .in_level_bits_a(in_level_bits_a), .in_level_bits_b(in_level_bits_b),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
`default_nettype wire
